// ===== tlsr_top.sv
// terminal lock, analog source select and fault-clear core with wishbone slave
//
// Register access over Wishbone and the register offsets were left to the implementer.
module tlsr_top
  import tlsr_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int FILT_TICKS = FILT_MS,
  parameter int AW = 4,
  parameter int DW = 16,
  parameter int AIW = 12
)
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_WR,
  output logic [31:0] WB_DAT_RD,
  output logic WB_ACK,
  input wire logic PARAM_LOCK_INPUT,
  input wire logic ANALOG_SOURCE_SELECT_INPUT,
  input wire logic FAULT_CLEAR_INPUT,
  input wire logic KEY_WE,
  input wire logic [AW-1:0] KEY_ADDR,
  input wire logic [DW-1:0] KEY_DATA,
  output logic KEY_ACK,
  output logic KEY_REFUSED,
  input wire logic [AIW-1:0] VOLT_IN,
  input wire logic [AIW-1:0] CURRENT_ANALOG_INPUT,
  input wire logic [AIW-1:0] POT_IN,
  input wire logic TRIP_IN,
  output logic [DW-1:0] FREQ_REF,
  output logic MOTOR_EN,
  output logic ALARM_OUT
);
  localparam int TW = $clog2(MS_CYC + 1);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [1:0] lock_scope_setting;
    logic [1:0] analog_select_mode;
    logic [1:0] freq_source_setting;
    logic run;
    logic [AW-1:0] paddr;
    logic trip;
    logic refused;
    tlsr_clr_t clr;
    logic [DW-1:0] freq;
    logic [DW-1:0] fref;
    tlsr_ana_t asel;
    logic motor;
    logic [TW-1:0] tcnt;
    logic tick;
  } tlsr_core_t;

  tlsr_core_t q, n;
  tlsr_link_if #(.N(N_TERM), .AW(AW), .DW(DW)) lnk ();

  tlsr_filter #(.N(N_TERM), .FILT_TICKS(FILT_TICKS)) u_filter (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .lnk(lnk.filt)
  );

  tlsr_store #(.AW(AW), .DW(DW)) u_store (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .lnk(lnk.store)
  );

  // word 0 of the store is the output frequency
  function automatic logic edit_ok(input logic [AW-1:0] a, input logic lk, input logic flk);
    edit_ok = (a == '0) ? !flk : !lk;
  endfunction

  logic lock_act;
  logic freq_lk;
  logic req;
  logic wr_go;
  logic bus_pd;
  logic bus_ok;
  logic key_ok;
  logic [DW-1:0] bus_word;

  assign lnk.raw = {FAULT_CLEAR_INPUT, ANALOG_SOURCE_SELECT_INPUT, PARAM_LOCK_INPUT};
  assign lnk.tick = q.tick;
  assign lock_act = lnk.clean[TERM_LOCK] | q.lock_scope_setting[CTRL_OP_LOCK_BIT];
  assign freq_lk = lock_act & q.lock_scope_setting[CTRL_FREQ_LOCK_BIT];
  assign req = WB_CYC & WB_STB & !q.ack;
  // writes land on the edge where the master samples ack
  assign wr_go = WB_CYC & WB_STB & WB_WE & q.ack;
  assign bus_pd = wr_go && (WB_ADR == ADDR_PDATA);
  assign bus_ok = bus_pd && edit_ok(q.paddr, lock_act, freq_lk);
  // a keypad write colliding with a bus write to ADDR_PDATA is neither taken nor refused
  assign key_ok = KEY_WE && !bus_pd && edit_ok(KEY_ADDR, lock_act, freq_lk);
  assign KEY_ACK = key_ok;
  assign KEY_REFUSED = KEY_WE && !bus_pd && !edit_ok(KEY_ADDR, lock_act, freq_lk);

  always_comb begin
    bus_word = lnk.rdata;
    for (int i = 0; i < DW / 8; i++) begin
      if (WB_SEL[i]) begin
        bus_word[8*i +: 8] = WB_DAT_WR[8*i +: 8];
      end
    end
  end

  assign lnk.we = bus_ok | key_ok;
  assign lnk.waddr = bus_ok ? q.paddr : KEY_ADDR;
  assign lnk.wdata = bus_ok ? bus_word : KEY_DATA;
  assign lnk.raddr = q.paddr;

  always_comb begin
    n = q;
    n.ack = req;
    if (q.tcnt == TW'(MS_CYC - 1)) begin
      n.tcnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tcnt = q.tcnt + TW'(1);
      n.tick = 1'b0;
    end
    if (req) begin
      n.rdat = '0;
      case (WB_ADR)
        ADDR_CTRL: n.rdat[1:0] = q.lock_scope_setting;
        ADDR_ANA: begin
          n.rdat[ANA_MODE_LSB +: 2] = q.analog_select_mode;
          n.rdat[ANA_SRC_LSB +: 2] = q.freq_source_setting;
        end
        ADDR_RUN: n.rdat[0] = q.run;
        ADDR_STAT: begin
          n.rdat[STAT_LOCK_BIT] = lock_act;
          n.rdat[STAT_FLOCK_BIT] = freq_lk;
          n.rdat[STAT_ASEL_LSB +: 2] = q.asel;
          n.rdat[STAT_TRIP_BIT] = q.trip;
          n.rdat[STAT_MOTOR_BIT] = q.motor;
          n.rdat[STAT_CLR_BIT] = (q.clr != CLR_IDLE);
          n.rdat[STAT_REFUSED_BIT] = q.refused;
        end
        ADDR_PADDR: n.rdat[AW-1:0] = q.paddr;
        ADDR_PDATA: n.rdat[DW-1:0] = lnk.rdata;
        default: n.rdat = '0;
      endcase
    end
    if (wr_go && WB_SEL[0]) begin
      case (WB_ADR)
        ADDR_CTRL: n.lock_scope_setting = WB_DAT_WR[1:0];
        ADDR_ANA: begin
          n.analog_select_mode = WB_DAT_WR[ANA_MODE_LSB +: 2];
          n.freq_source_setting = WB_DAT_WR[ANA_SRC_LSB +: 2];
        end
        ADDR_RUN: n.run = WB_DAT_WR[0];
        ADDR_STAT: begin
          if (WB_DAT_WR[STAT_REFUSED_BIT]) begin
            n.refused = 1'b0;
          end
        end
        ADDR_PADDR: n.paddr = WB_DAT_WR[AW-1:0];
        default: n.paddr = q.paddr;
      endcase
    end
    // refusal set wins over a status-register clear in the same cycle
    if ((bus_pd && !bus_ok) || KEY_REFUSED) begin
      n.refused = 1'b1;
    end
    if (lnk.we && lnk.waddr == '0) begin
      n.freq = lnk.wdata;
    end
    case (q.analog_select_mode)
      MODE_CUR_VOLT: n.asel = lnk.clean[TERM_SEL] ? SRC_CUR : SRC_VOLT;
      MODE_POT_VOLT: n.asel = lnk.clean[TERM_SEL] ? SRC_POT : SRC_VOLT;
      MODE_POT_CUR: n.asel = lnk.clean[TERM_SEL] ? SRC_POT : SRC_CUR;
      default: n.asel = SRC_VOLT;
    endcase
    if (q.freq_source_setting == FSRC_ANALOG) begin
      case (n.asel)
        SRC_CUR: n.fref = DW'(CURRENT_ANALOG_INPUT);
        SRC_POT: n.fref = DW'(POT_IN);
        default: n.fref = DW'(VOLT_IN);
      endcase
    end else begin
      n.fref = q.freq;
    end
    case (q.clr)
      CLR_IDLE: begin
        if (lnk.clean[TERM_CLR]) begin
          n.clr = CLR_HOLD;
        end
      end
      CLR_HOLD: begin
        if (!lnk.clean[TERM_CLR]) begin
          n.clr = CLR_DONE;
        end
      end
      CLR_DONE: n.clr = CLR_IDLE;
      default: n.clr = CLR_IDLE;
    endcase
    n.trip = q.trip | TRIP_IN;
    // clear dominates a trip arriving while the clear is held
    if (n.clr == CLR_HOLD) begin
      n.trip = 1'b0;
      n.refused = 1'b0;
    end
    n.motor = n.run & !n.trip & (n.clr != CLR_HOLD);
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign WB_ACK = q.ack;
  assign WB_DAT_RD = q.rdat;
  assign FREQ_REF = q.fref;
  assign MOTOR_EN = q.motor;
  assign ALARM_OUT = q.trip;

  // helper: whole milliseconds since the fault-clear pin rose, and whether hold followed;
  // the pin goes through its own two flops first, it is not of this clock
  logic [2:0] clr_sync_q;
  logic [7:0] onset_ms_q;
  logic hold_seen_q;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      clr_sync_q <= '0;
      onset_ms_q <= 8'hff;
      hold_seen_q <= 1'b0;
    end else begin
      clr_sync_q <= {clr_sync_q[1:0], FAULT_CLEAR_INPUT};
      if (clr_sync_q[1] && !clr_sync_q[2]) begin
        onset_ms_q <= 8'h00;
        hold_seen_q <= 1'b0;
      end else begin
        // saturates, so a stale onset never re-arms the check
        if (q.tick && onset_ms_q != 8'hff) begin
          onset_ms_q <= onset_ms_q + 8'h01;
        end
        if (q.clr == CLR_HOLD) begin
          hold_seen_q <= 1'b1;
        end
      end
    end
  end

  property p_lock_refuse;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (lnk.we && lock_act) |-> (lnk.waddr == '0 && !freq_lk);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("edit stored while locked");

  property p_key_refuse;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (KEY_WE && !bus_pd && KEY_ADDR != '0 && lock_act) |-> (KEY_REFUSED && !KEY_ACK);
  endproperty
  a_key_refuse: assert property (p_key_refuse) else $error("keypad edit not refused");

  property p_refused_set;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (KEY_REFUSED && q.clr == CLR_IDLE && !lnk.clean[TERM_CLR]) |=> q.refused;
  endproperty
  a_refused_set: assert property (p_refused_set) else $error("refusal not recorded");

  property p_unlock_store;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (bus_pd && !lock_act) |-> lnk.we ##1 (q.paddr != '0 || q.freq == $past(bus_word));
  endproperty
  a_unlock_store: assert property (p_unlock_store) else $error("unlocked edit not stored");

  property p_scope_freq;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (KEY_WE && !bus_pd && KEY_ADDR == '0 && lock_act)
      |-> (KEY_ACK == !q.lock_scope_setting[CTRL_FREQ_LOCK_BIT]);
  endproperty
  a_scope_freq: assert property (p_scope_freq) else $error("frequency lock scope wrong");

  property p_op_lock;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.lock_scope_setting[CTRL_OP_LOCK_BIT] && KEY_WE && !bus_pd && KEY_ADDR != '0)
      |-> KEY_REFUSED;
  endproperty
  a_op_lock: assert property (p_op_lock) else $error("operator lock ignored");

  property p_sel_cur;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.freq_source_setting == FSRC_ANALOG && q.analog_select_mode == MODE_CUR_VOLT)
      |=> (FREQ_REF == DW'($past(lnk.clean[TERM_SEL]) ? $past(CURRENT_ANALOG_INPUT)
                                                       : $past(VOLT_IN)));
  endproperty
  a_sel_cur: assert property (p_sel_cur) else $error("mode 00 routing wrong");

  property p_sel_pot;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.freq_source_setting == FSRC_ANALOG && lnk.clean[TERM_SEL] && q.analog_select_mode[1])
      |=> (FREQ_REF == DW'($past(POT_IN)));
  endproperty
  a_sel_pot: assert property (p_sel_pot) else $error("pot not routed");

  property p_src_param;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.freq_source_setting != FSRC_ANALOG) |=> (FREQ_REF == $past(q.freq));
  endproperty
  a_src_param: assert property (p_src_param) else $error("select acted off analog source");

  property p_release;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.clr == CLR_HOLD && !lnk.clean[TERM_CLR]) |=> (q.clr == CLR_DONE) ##1 (q.clr == CLR_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("reset operation not run");

  property p_hold_off;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.clr == CLR_HOLD) |-> (!ALARM_OUT && !MOTOR_EN);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("trip or motor during clear");

  property p_alarm_time;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (onset_ms_q == 8'(ALARM_CLR_MS - 1)) |-> (hold_seen_q || q.clr == CLR_HOLD);
  endproperty
  a_alarm_time: assert property (p_alarm_time) else $error("alarm not cleared in time");

  property p_trip_clear;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.trip && q.clr == CLR_IDLE && lnk.clean[TERM_CLR]) |=> !q.trip;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip survived clear");

  property p_resume;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (q.clr == CLR_DONE && q.run && !q.trip && !TRIP_IN && !wr_go) |=> MOTOR_EN;
  endproperty
  a_resume: assert property (p_resume) else $error("motor did not resume");
endmodule

// ===== tlsr_pkg.sv
// shared constants and types for the terminal lock / select / reset block
package tlsr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_MS = 4;
  localparam int RST_MIN_MS = 12;
  localparam int ALARM_CLR_MS = 30;
  localparam int N_TERM = 3;
  localparam int TERM_LOCK = 0;
  localparam int TERM_SEL = 1;
  localparam int TERM_CLR = 2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ANA = 8'h04;
  localparam logic [7:0] ADDR_RUN = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_PADDR = 8'h10;
  localparam logic [7:0] ADDR_PDATA = 8'h14;
  localparam int CTRL_FREQ_LOCK_BIT = 0;
  localparam int CTRL_OP_LOCK_BIT = 1;
  localparam int ANA_MODE_LSB = 0;
  localparam int ANA_SRC_LSB = 4;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_FLOCK_BIT = 1;
  localparam int STAT_ASEL_LSB = 2;
  localparam int STAT_TRIP_BIT = 4;
  localparam int STAT_MOTOR_BIT = 5;
  localparam int STAT_CLR_BIT = 6;
  localparam int STAT_REFUSED_BIT = 7;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] MODE_CUR_VOLT = 2'h0;
  localparam logic [1:0] MODE_POT_VOLT = 2'h2;
  localparam logic [1:0] MODE_POT_CUR = 2'h3;
  localparam logic [1:0] FSRC_PARAM = 2'h0;
  localparam logic [1:0] FSRC_ANALOG = 2'h1;
  typedef enum logic [1:0] {SRC_VOLT = 2'b00, SRC_CUR = 2'b01, SRC_POT = 2'b10} tlsr_ana_t;
  typedef enum logic [1:0] {CLR_IDLE = 2'b00, CLR_HOLD = 2'b01, CLR_DONE = 2'b10} tlsr_clr_t;
endpackage

// ===== tlsr_link_if.sv
// carrier between the core and its filter and parameter store
interface tlsr_link_if #(parameter int N = 3, parameter int AW = 4, parameter int DW = 16);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  logic tick;
  logic we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport filt(input raw, input tick, output clean);
  modport store(input we, input waddr, input wdata, input raddr, output rdata);
  modport core(output raw, output tick, output we, output waddr, output wdata, output raddr,
               input clean, input rdata);
endinterface

// ===== tlsr_filter.sv
// two-flop synchroniser and millisecond debounce per terminal
module tlsr_filter
  import tlsr_pkg::*;
#(parameter int N = 3, parameter int FILT_TICKS = FILT_MS)
(
  input wire logic clk,
  input wire logic rst_b,
  tlsr_link_if.filt lnk
);
  localparam int CW = $clog2(FILT_TICKS + 1);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] clean;
    logic [N-1:0][CW-1:0] cnt;
  } tlsr_filt_t;
  tlsr_filt_t q, d;

  always_comb begin
    d = q;
    d.s1 = lnk.raw;
    d.s2 = q.s1;
    for (int i = 0; i < N; i++) begin
      if (q.s2[i] == q.clean[i]) begin
        d.cnt[i] = '0;
      end else if (lnk.tick) begin
        // level must hold for the whole window before it is believed
        if (q.cnt[i] == CW'(FILT_TICKS - 1)) begin
          d.clean[i] = q.s2[i];
          d.cnt[i] = '0;
        end else begin
          d.cnt[i] = q.cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.clean = q.clean;

  for (genvar g = 0; g < N; g++) begin : g_chk
    property p_filt_hold;
      @(posedge clk) disable iff (!rst_b)
      (q.clean[g] != $past(q.clean[g])) |-> ($past(lnk.tick) && $past(q.cnt[g]) == CW'(FILT_TICKS - 1));
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("terminal changed before filter time");
  end
endmodule

// ===== tlsr_store.sv
// parameter word store, registered read port
module tlsr_store
  import tlsr_pkg::*;
#(parameter int AW = 4, parameter int DW = 16)
(
  input wire logic clk,
  input wire logic rst_b,
  tlsr_link_if.store lnk
);
  typedef struct packed {
    logic [(1 << AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } tlsr_mem_t;
  tlsr_mem_t q, d;

  always_comb begin
    d = q;
    if (lnk.we) begin
      d.mem[lnk.waddr] = lnk.wdata;
    end
    // old contents on a same-address write; reader sees new word next cycle
    d.rdata = q.mem[lnk.raddr];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.rdata = q.rdata;
endmodule

// ===== tlsr_term_model.sv
// terminal-side controller model: contact levels and timed fault-clear pulse
module tlsr_term_model
  import tlsr_pkg::*;
#(parameter int MS_CYC = 20)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic lock_req,
  input wire logic sel_req,
  input wire logic clr_req,
  output logic lock_pin,
  output logic sel_pin,
  output logic clr_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // contacts follow the request directly; glitches are the bench's to make
  assign lock_pin = lock_req;
  assign sel_pin = sel_req;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      clr_pin <= 1'b0;
    end else if (clr_req && cnt == 0) begin
      cnt <= RST_MIN_MS * MS_CYC;
      clr_pin <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      clr_pin <= 1'b0;
    end
  end
endmodule

// ===== terminal_lock_select_reset_bench.sv
// self-checking bench for the terminal lock / select / reset block
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((e) !== (g)) begin \
    fails++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); \
  end \
end
module terminal_lock_select_reset_bench
  import tlsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 20;
  typedef struct packed {logic [5:0] ana; logic sel; logic [15:0] f;} tlsr_brow_t;
  localparam tlsr_brow_t ROWS [8] = '{'{6'h10, 1'b0, 16'h0123}, '{6'h10, 1'b1, 16'h0456},
    '{6'h12, 1'b0, 16'h0123}, '{6'h12, 1'b1, 16'h0789}, '{6'h13, 1'b0, 16'h0456},
    '{6'h13, 1'b1, 16'h0789}, '{6'h11, 1'b1, 16'h0123}, '{6'h03, 1'b1, 16'h0abc}};
  logic clk, rst_b, cyc, stb, we, ack, kwe, kack, kref, trip, motor, alarm;
  logic lock_req, sel_req, clr_req, lock_pin, sel_pin, clr_pin;
  logic [7:0] adr;
  logic [3:0] sel, kad;
  logic [31:0] dw, dr, rd;
  logic [15:0] kda, fref;
  int fails, total_checks, n;

  tlsr_top #(.MS_CYC(MS), .FILT_TICKS(4)) i_tlsr_top (.CLK_SYS(clk), .RST_B(rst_b),
    .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_WR(dw),
    .WB_DAT_RD(dr), .WB_ACK(ack), .PARAM_LOCK_INPUT(lock_pin),
    .ANALOG_SOURCE_SELECT_INPUT(sel_pin), .FAULT_CLEAR_INPUT(clr_pin), .KEY_WE(kwe),
    .KEY_ADDR(kad), .KEY_DATA(kda), .KEY_ACK(kack), .KEY_REFUSED(kref),
    .VOLT_IN(12'h123), .CURRENT_ANALOG_INPUT(12'h456), .POT_IN(12'h789), .TRIP_IN(trip),
    .FREQ_REF(fref), .MOTOR_EN(motor), .ALARM_OUT(alarm));
  tlsr_term_model #(.MS_CYC(MS)) i_tlsr_term_model (.clk(clk), .rst_b(rst_b),
    .lock_req(lock_req), .sel_req(sel_req), .clr_req(clr_req), .lock_pin(lock_pin),
    .sel_pin(sel_pin), .clr_pin(clr_pin));

  always #50 clk = ~clk;

  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic w);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    // held until the edge that sees ack; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic key(input logic [3:0] a, input logic [15:0] d, input logic ea);
    @(posedge clk);
    kwe <= 1'b1;
    kad <= a;
    kda <= d;
    @(negedge clk);
    `CHK("key_ack", ea, kack)
    `CHK("key_refused", ~ea, kref)
    @(posedge clk);
    kwe <= 1'b0;
  endtask

  task automatic wait_ms(input int m);
    repeat (m * MS) @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    clk = 0;
    rst_b = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    sel = 0;
    dw = 0;
    kwe = 0;
    kad = 0;
    kda = 0;
    trip = 0;
    lock_req = 0;
    sel_req = 0;
    clr_req = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("reset_outs", 19'h0, {fref, motor, alarm, ack})
    wb(ADDR_STAT, 0, 4'hf, 0);
    `CHK("stat_reset", 32'h0, rd)
    wb(8'h20, 32'hffff, 4'hf, 1);
    wb(8'h20, 0, 4'hf, 0);
    `CHK("unmapped", 32'h0, rd)
    // lock glitch of 1 ms must not reach the lock logic
    @(posedge clk) lock_req <= 1'b1;
    wait_ms(1);
    lock_req <= 1'b0;
    wait_ms(6);
    key(4'h3, 16'h1111, 1'b1);
    wb(ADDR_PADDR, 3, 4'hf, 1);
    wb(ADDR_PDATA, 0, 4'hf, 0);
    `CHK("pdata_stored", 32'h1111, rd)
    @(posedge clk) lock_req <= 1'b1;
    wait_ms(6);
    wb(ADDR_PDATA, 32'h2222, 4'hf, 1);
    wb(ADDR_PDATA, 0, 4'hf, 0);
    `CHK("pdata_locked", 32'h1111, rd)
    wb(ADDR_STAT, 0, 4'hf, 0);
    `CHK("stat_lock_refused", 2'b11, {rd[STAT_REFUSED_BIT], rd[STAT_LOCK_BIT]})
    key(4'h3, 16'h5555, 1'b0);
    key(4'h0, 16'h0abc, 1'b1);
    wb(ADDR_CTRL, 1, 4'he, 1);
    key(4'h0, 16'h0abc, 1'b1);
    wb(ADDR_CTRL, 1, 4'h1, 1);
    key(4'h0, 16'h0def, 1'b0);
    @(posedge clk) lock_req <= 1'b0;
    wait_ms(6);
    key(4'h3, 16'h6666, 1'b1);
    // lane 0 only: upper byte keeps the stored word
    wb(ADDR_PDATA, 32'h3333, 4'h1, 1);
    wb(ADDR_PDATA, 0, 4'hf, 0);
    `CHK("pdata_bus_store", 32'h6633, rd)
    wb(ADDR_CTRL, 2, 4'h1, 1);
    key(4'h3, 16'h7777, 1'b0);
    key(4'h0, 16'h0111, 1'b1);
    wb(ADDR_CTRL, 0, 4'h1, 1);
    key(4'h0, 16'h0abc, 1'b1);
    foreach (ROWS[i]) begin
      wb(ADDR_ANA, {26'h0, ROWS[i].ana}, 4'h1, 1);
      @(posedge clk) sel_req <= ROWS[i].sel;
      wait_ms(6);
      `CHK("freq_ref", ROWS[i].f, fref)
    end
    wb(ADDR_RUN, 1, 4'h1, 1);
    repeat (3) @(negedge clk);
    `CHK("motor_run", 1'b1, motor)
    @(posedge clk) trip <= 1'b1;
    @(posedge clk) trip <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("trip_alarm", 2'b10, {alarm, motor})
    @(posedge clk) clr_req <= 1'b1;
    @(posedge clk) clr_req <= 1'b0;
    n = 1;
    while (alarm === 1'b1 && n < 40 * MS) begin
      @(negedge clk);
      n++;
    end
    `CHK("alarm_cleared_in_time", 1'b1, n < ALARM_CLR_MS * MS)
    `CHK("hold_motor_off", 2'b10, {clr_pin, motor})
    wb(ADDR_STAT, 0, 4'hf, 0);
    `CHK("stat_hold", 3'b100, {rd[STAT_CLR_BIT], rd[STAT_REFUSED_BIT], rd[STAT_TRIP_BIT]})
    while (motor !== 1'b1 && n < 40 * MS) begin
      @(negedge clk);
      n++;
    end
    // restart only after the terminal went off again
    `CHK("restart_after_release", 2'b01, {clr_pin, motor})
    // run past the onset-to-alarm window that the design's own check watches
    wait_ms(14);
    `CHK("alarm_stays_off", 2'b01, {alarm, motor})
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    @(negedge clk);
    `CHK("reset_again_outs", 19'h0, {fref, motor, alarm, ack})
    wb(ADDR_RUN, 0, 4'hf, 0);
    `CHK("reset_again_run", 32'h0, rd)
    summarize();
  end
endmodule
